// ### cmd_link_if.sv
/*
  Link between the host controller and the reader command logic.
  Assumes both ends run on the same clock; no clocking block.
*/
`timescale 1ns/10ps
`default_nettype none
interface cmd_link_if;
  import value_recover_pkg::*;
  // Host to device
  logic cmd_valid;
  logic [7:0] cmd_code;
  logic [ARG_W-1:0] cmd_args;
  logic [BUF_AW-1:0] buf_addr;
  // Device to host
  logic busy;
  logic done;
  logic [7:0] result;
  logic [7:0] buf_data;

  modport device (
    input cmd_valid, cmd_code, cmd_args, buf_addr,
    output busy, done, result, buf_data
  );
  modport host (
    output cmd_valid, cmd_code, cmd_args, buf_addr,
    input busy, done, result, buf_data
  );
endinterface
`default_nettype wire

// ### test_value_block_recovery_command.sv
/*
  Self-checking bench: host and reader ends joined by the link,
  AXI4-Lite master tasks, a card responder and a table of commands.
  Assumes package, link, both ends and the checker compile first.
*/
`timescale 1ns/10ps
`default_nettype none
module test_value_block_recovery_command;
  import value_recover_pkg::*;
  typedef struct packed {
    logic [7:0] code, blk, ofs, sel;
    logic [47:0] key;
    logic [31:0] v;
    logic [7:0] a;
    logic [127:0] mask;
    logic auth;
    logic [7:0] res;
  } row_t;
  logic clock_in, reset_in, awvalid, awready, wvalid, wready, bvalid, bready;
  logic arvalid, arready, rvalid, rready, card_req, card_key_b, card_ack, card_auth;
  logic key_wr, seen_b;
  logic [7:0] awaddr, araddr, card_blk, seen_blk;
  logic [31:0] wdata, rdata, got;
  logic [1:0] bresp, rresp, resp;
  logic [47:0] card_key, key_data, seen_key;
  logic [127:0] card_data;
  logic [5:0] key_idx;
  logic [7:0] mem [256];
  int n_req, rc, cyc;
  int n_fail = 0;
  int checks = 0;
  row_t rows [7];

  cmd_link_if link ();
  value_recover_device i_value_recover_device (.clock_in(clock_in), .reset_in(reset_in),
    .link(link), .card_req_out(card_req), .card_block_out(card_blk),
    .card_key_out(card_key), .card_key_b_out(card_key_b), .card_ack_in(card_ack),
    .card_auth_ok_in(card_auth), .card_data_in(card_data), .key_wr_in(key_wr),
    .key_wr_index_in(key_idx), .key_wr_data_in(key_data));
  value_recover_host i_value_recover_host (.clock_in(clock_in), .reset_in(reset_in),
    .axi_awvalid_in(awvalid), .axi_awready_out(awready), .axi_awaddr_in(awaddr),
    .axi_wvalid_in(wvalid), .axi_wready_out(wready), .axi_wdata_in(wdata),
    .axi_wstrb_in(4'hF), .axi_bvalid_out(bvalid), .axi_bready_in(bready),
    .axi_bresp_out(bresp), .axi_arvalid_in(arvalid), .axi_arready_out(arready),
    .axi_araddr_in(araddr), .axi_rvalid_out(rvalid), .axi_rready_in(rready),
    .axi_rdata_out(rdata), .axi_rresp_out(rresp), .link(link));
  value_recover_props i_value_recover_props (.clock_in(clock_in), .reset_in(reset_in),
    .cmd_valid(link.cmd_valid), .cmd_code(link.cmd_code), .cmd_args(link.cmd_args),
    .busy(link.busy), .done(link.done), .result(link.result));

  // Clock
  initial begin
    clock_in = 1'b0;
    forever #4 clock_in = ~clock_in;
  end

  // Card side: answers each request four cycles late
  always @(posedge clock_in) begin
    card_ack <= 1'b0;
    if (reset_in) begin
      rc <= 0;
    end else if (card_req && !card_ack) begin
      if (rc == 3) begin
        card_ack <= 1'b1;
        rc <= 0;
        seen_blk <= card_blk;
        seen_key <= card_key;
        seen_b <= card_key_b;
        n_req <= n_req + 1;
      end else begin
        rc <= rc + 1;
      end
    end
  end

  // Hang guard
  always @(posedge clock_in) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      n_fail++;
      final_report();
    end
  end

  function automatic logic [127:0] blk_of(input logic [31:0] v, input logic [7:0] a);
    return {~a, a, ~a, a, v, ~v, v};
  endfunction
  function automatic logic [47:0] key_of(input logic [5:0] i);
    return {36'h5A3C96E1F, 6'h00, i};
  endfunction

  task automatic check(input logic [47:0] seen, input logic [47:0] exp, input string what);
    checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("wrong value at %0t: %s got %h expected %h", $time, what, seen, exp);
    end
  endtask

  task automatic final_report;
    $display("checks %0d, mismatches %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask

  // Bus master: one write, held until each channel is taken
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clock_in);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge clock_in);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (!bvalid);
    resp = bresp;
    bready <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a);
    @(posedge clock_in);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge clock_in);
      if (arready) arvalid <= 1'b0;
    end while (!rvalid);
    got = rdata;
    resp = rresp;
    rready <= 1'b0;
  endtask

  // One command: arguments, start, poll, card and buffer checks
  task automatic run(input row_t x);
    wr(REG_ARG0, {x.key[7:0], x.sel, x.ofs, x.blk});
    wr(REG_ARG1, x.key[39:8]);
    wr(REG_ARG2, {24'h000000, x.key[47:40]});
    card_auth <= x.auth;
    card_data <= blk_of(x.v, x.a) ^ x.mask;
    n_req = 0;
    wr(REG_CMD, {24'h000000, x.code});
    do rd(REG_STATUS); while (got[STAT_DONE_BIT] !== 1'b1);
    check(got[15:8], x.res, "result");
    check(got[STAT_BUSY_BIT], 0, "busy");
    wr(REG_STATUS, 32'h00000002);
    // Card is reached only for codes below the refusal codes
    check(48'(n_req), 48'(x.res < RES_BAD_CMD), "card use");
    if (n_req == 1) begin
      check(seen_blk, x.blk, "block");
      check(seen_b, x.sel[7], "key type");
      check(seen_key, x.sel[6] ? x.key : key_of(x.sel[5:0]), "key");
    end
    if (x.res == RES_OK) begin
      for (int j = 0; j < 4; j++) mem[8'(x.ofs + j)] = x.v[8*j +: 8];
      mem[8'(x.ofs + 4)] = x.a;
    end
    for (int i = 0; i < 5; i++) begin
      wr(REG_BUF_ADDR, {24'h000000, 8'(x.ofs + i)});
      rd(REG_BUF_DATA);
      check(got[7:0], mem[8'(x.ofs + i)], "buffer");
    end
    $display("command %h sel %h finished, result %h", x.code, x.sel, x.res);
  endtask

  // Main sequence
  initial begin
    reset_in = 1'b1;
    {awvalid, wvalid, bready, arvalid, rready, key_wr, card_auth} = '0;
    {awaddr, araddr, wdata, key_idx, key_data, card_data, cyc, rc, n_req} = '0;
    rows[0] = '{8'h10, 8'h04, 8'h00, 8'h00, 48'h0, 32'h12345678, 8'h04, 128'h0, 1'b1, RES_OK};
    rows[1] = '{8'h10, 8'h3F, 8'h10, 8'hA7, 48'h0, 32'hFFFFFF85, 8'h3F,
      128'h1_0000_0000_0000_0000_0000_0008, 1'b1, RES_OK};
    rows[2] = '{8'h10, 8'h80, 8'hFE, 8'hC0, 48'h665544332211, 32'h80000000, 8'h80,
      128'hFF_0000_0000, 1'b1, RES_OK};
    rows[3] = '{8'h10, 8'h05, 8'h00, 8'h41, 48'h0A0B0C0D0E0F, 32'h1, 8'h05, 128'h0, 1'b0,
      RES_AUTH_FAIL};
    rows[4] = '{8'h10, 8'h06, 8'h10, 8'h02, 48'h0, 32'h55AA55AA, 8'h06,
      128'h4_0000_0002_0000_0001, 1'b1, RES_CORRUPT};
    rows[5] = '{8'h11, 8'h04, 8'h00, 8'h00, 48'h0, 32'h0, 8'h00, 128'h0, 1'b1, RES_BAD_CMD};
    rows[6] = '{8'h10, 8'h04, 8'hFE, 8'h28, 48'h0, 32'h0, 8'h00, 128'h0, 1'b1, RES_BAD_KEY};
    repeat (4) @(posedge clock_in);
    reset_in <= 1'b0;
    for (int i = 0; i < 40; i++) begin
      @(posedge clock_in);
      key_wr <= 1'b1;
      key_idx <= 6'(i);
      key_data <= key_of(6'(i));
    end
    @(posedge clock_in);
    key_wr <= 1'b0;
    foreach (rows[i]) run(rows[i]);
    // Unmapped word refused on both channels
    wr(8'h1C, 32'hFFFFFFFF);
    check(resp, RESP_SLVERR, "write response");
    rd(8'h1C);
    check(got, 0, "unmapped data");
    check(resp, RESP_SLVERR, "read response");
    $display("unmapped access finished");
    // Reset in mid-command, then a clean command again
    wr(REG_ARG0, {8'h00, rows[0].sel, rows[0].ofs, rows[0].blk});
    wr(REG_CMD, {24'h000000, CMD_RECOVER_VALUE});
    @(posedge clock_in);
    reset_in <= 1'b1;
    repeat (2) @(posedge clock_in);
    reset_in <= 1'b0;
    rd(REG_STATUS);
    check(got, 0, "status after reset");
    run(rows[0]);
    final_report();
  end
endmodule
`default_nettype wire

// ### value_recover_device.sv
/*
  Reader-side command logic for value-block recovery: decodes the
  command, picks the key, asks the card for the block, votes the
  redundant copies and stores value and address in the data buffer.
  Assumes a card port that holds ack one cycle with data and status,
  and a key store loaded through the key port.
*/
`timescale 1ns/10ps
`default_nettype none
module value_recover_device (
  // Clock and reset
  input wire logic clock_in,
  input wire logic reset_in,
  // Host link
  cmd_link_if.device link,
  // Card access
  output logic card_req_out,
  output logic [7:0] card_block_out,
  output logic [value_recover_pkg::KEY_W-1:0] card_key_out,
  output logic card_key_b_out,
  input wire logic card_ack_in,
  input wire logic card_auth_ok_in,
  input wire logic [value_recover_pkg::BLOCK_W-1:0] card_data_in,
  // Key store loading
  input wire logic key_wr_in,
  input wire logic [value_recover_pkg::KEY_IDX_W-1:0] key_wr_index_in,
  input wire logic [value_recover_pkg::KEY_W-1:0] key_wr_data_in
);
  import value_recover_pkg::*;

  typedef enum logic [2:0] {
    ST_IDLE = 3'h0,
    ST_CARD = 3'h1,
    ST_CHECK = 3'h3,
    ST_WRITE = 3'h2,
    ST_DONE = 3'h6
  } state_t;

  // Byte pick from the argument list
  function automatic logic [7:0] arg_byte(input logic [ARG_W-1:0] args,
                                          input int idx);
    arg_byte = args[idx*8 +: 8];
  endfunction

  // Bitwise two-of-three vote
  function automatic logic [31:0] vote3(input logic [31:0] a,
                                        input logic [31:0] b,
                                        input logic [31:0] c);
    vote3 = (a & b) | (a & c) | (b & c);
  endfunction

  // Storage
  logic [7:0] buffer_mem [BUF_DEPTH];
  logic [KEY_W-1:0] key_mem [KEY_COUNT];

  // State and registers
  state_t state_reg;
  logic busy_reg;
  logic done_reg;
  logic [7:0] result_reg;
  logic [7:0] buf_data_reg;
  logic card_req_reg;
  logic [7:0] block_reg;
  logic [KEY_W-1:0] key_reg;
  logic key_b_reg;
  logic [BUF_AW-1:0] wr_ptr_reg;
  logic [BLOCK_W-1:0] data_reg;
  logic [RESULT_BYTES*8-1:0] out_bytes_reg;
  logic [2:0] byte_cnt_reg;

  // Decode of the incoming command and selector
  wire [7:0] sel_byte = arg_byte(link.cmd_args, ARG_KEY_SEL);
  wire [KEY_IDX_W-1:0] key_index = sel_byte[KEY_IDX_W-1:0];
  wire use_inline = sel_byte[SEL_INLINE_BIT];
  wire use_key_b = sel_byte[SEL_KEY_B_BIT];
  wire index_ok = use_inline || (key_index <= KEY_LAST);
  wire is_recover = link.cmd_code == CMD_RECOVER_VALUE;
  wire start = (state_reg == ST_IDLE) && link.cmd_valid;

  // Key choice: inline bytes LSB first, else key store
  wire [KEY_W-1:0] inline_key = link.cmd_args[ARG_KEY*8 +: KEY_W];
  wire [KEY_W-1:0] stored_key = (key_index <= KEY_LAST) ? key_mem[key_index] : '0;
  wire [KEY_W-1:0] chosen_key = use_inline ? inline_key : stored_key;

  // Copies of value and address inside the value block
  wire [31:0] val_a = data_reg[31:0];
  wire [31:0] val_b = ~data_reg[63:32];
  wire [31:0] val_c = data_reg[95:64];
  wire [31:0] adr_a = {24'h000000, data_reg[103:96]};
  wire [31:0] adr_b = {24'h000000, ~data_reg[111:104]};
  wire [31:0] adr_c = {24'h000000, data_reg[119:112]};

  // Voting and plausibility of the result
  wire [31:0] val_vote = vote3(val_a, val_b, val_c);
  wire [31:0] adr_vote = vote3(adr_a, adr_b, adr_c);
  wire val_ok = (val_vote == val_a) || (val_vote == val_b) || (val_vote == val_c);
  wire adr_ok = (adr_vote == adr_a) || (adr_vote == adr_b) || (adr_vote == adr_c);
  wire block_ok = val_ok && adr_ok;

  // Buffer write strobe and last byte
  wire buf_we = state_reg == ST_WRITE;
  wire last_byte = byte_cnt_reg == RESULT_LAST;

  // Command sequencer
  always_ff @(posedge clock_in) begin
    if (reset_in) begin
      state_reg <= ST_IDLE;
      busy_reg <= 1'b0;
      result_reg <= RES_OK;
      card_req_reg <= 1'b0;
    end else begin
      unique case (state_reg)
        ST_IDLE: begin
          if (start) begin
            busy_reg <= 1'b1;
            if (!is_recover) begin
              result_reg <= RES_BAD_CMD;
              state_reg <= ST_DONE;
            end else if (!index_ok) begin
              result_reg <= RES_BAD_KEY;
              state_reg <= ST_DONE;
            end else begin
              card_req_reg <= 1'b1;
              state_reg <= ST_CARD;
            end
          end
        end
        ST_CARD: begin
          if (card_ack_in) begin
            card_req_reg <= 1'b0;
            if (card_auth_ok_in) begin
              state_reg <= ST_CHECK;
            end else begin
              result_reg <= RES_AUTH_FAIL;
              state_reg <= ST_DONE;
            end
          end
        end
        ST_CHECK: begin
          if (block_ok) begin
            state_reg <= ST_WRITE;
          end else begin
            result_reg <= RES_CORRUPT;
            state_reg <= ST_DONE;
          end
        end
        ST_WRITE: begin
          if (last_byte) begin
            result_reg <= RES_OK;
            state_reg <= ST_DONE;
          end
        end
        ST_DONE: begin
          busy_reg <= 1'b0;
          state_reg <= ST_IDLE;
        end
        default: begin
          state_reg <= ST_IDLE;
        end
      endcase
    end
  end

  // Completion pulse, one cycle after the finish state
  always_ff @(posedge clock_in) begin
    if (reset_in) begin
      done_reg <= 1'b0;
    end else begin
      done_reg <= state_reg == ST_DONE;
    end
  end

  // Card request fields, captured at command start
  always_ff @(posedge clock_in) begin
    if (reset_in) begin
      block_reg <= 8'h00;
      key_reg <= '0;
      key_b_reg <= 1'b0;
    end else if (start) begin
      block_reg <= arg_byte(link.cmd_args, ARG_BLOCK);
      key_reg <= chosen_key;
      key_b_reg <= use_key_b;
    end
  end

  // Block data from the card
  always_ff @(posedge clock_in) begin
    if (reset_in) begin
      data_reg <= '0;
    end else if (state_reg == ST_CARD && card_ack_in) begin
      data_reg <= card_data_in;
    end
  end

  // Result bytes: value LSB first, then address
  always_ff @(posedge clock_in) begin
    if (reset_in) begin
      out_bytes_reg <= '0;
      byte_cnt_reg <= 3'h0;
      wr_ptr_reg <= '0;
    end else if (start) begin
      byte_cnt_reg <= 3'h0;
      wr_ptr_reg <= arg_byte(link.cmd_args, ARG_BUF_OFS);
    end else if (state_reg == ST_CHECK) begin
      out_bytes_reg <= {adr_vote[7:0], val_vote};
    end else if (buf_we) begin
      out_bytes_reg <= {8'h00, out_bytes_reg[RESULT_BYTES*8-1:8]};
      byte_cnt_reg <= byte_cnt_reg + 3'h1;
      wr_ptr_reg <= wr_ptr_reg + 8'h01;
    end
  end

  // Data buffer, written only after a good vote
  always_ff @(posedge clock_in) begin
    if (buf_we) begin
      buffer_mem[wr_ptr_reg] <= out_bytes_reg[7:0];
    end
  end

  // Key store
  always_ff @(posedge clock_in) begin
    if (key_wr_in && key_wr_index_in <= KEY_LAST) begin
      key_mem[key_wr_index_in] <= key_wr_data_in;
    end
  end

  // Buffer read port, one cycle latency
  always_ff @(posedge clock_in) begin
    if (reset_in) begin
      buf_data_reg <= 8'h00;
    end else begin
      buf_data_reg <= buffer_mem[link.buf_addr];
    end
  end

  // Outputs
  assign link.busy = busy_reg;
  assign link.done = done_reg;
  assign link.result = result_reg;
  assign link.buf_data = buf_data_reg;
  assign card_req_out = card_req_reg;
  assign card_block_out = block_reg;
  assign card_key_out = key_reg;
  assign card_key_b_out = key_b_reg;

endmodule
`default_nettype wire

// ### value_recover_host.sv
/*
  Host controller end: an AXI4-Lite slave register file from which
  software issues the recovery command and reads status and buffer.
  Assumes the reader end on the link and one clock for both.
*/
`timescale 1ns/10ps
`default_nettype none
module value_recover_host (
  // Clock and reset
  input wire logic clock_in,
  input wire logic reset_in,
  // Write address and data
  input wire logic axi_awvalid_in,
  output logic axi_awready_out,
  input wire logic [7:0] axi_awaddr_in,
  input wire logic axi_wvalid_in,
  output logic axi_wready_out,
  input wire logic [31:0] axi_wdata_in,
  input wire logic [3:0] axi_wstrb_in,
  // Write response
  output logic axi_bvalid_out,
  input wire logic axi_bready_in,
  output logic [1:0] axi_bresp_out,
  // Read
  input wire logic axi_arvalid_in,
  output logic axi_arready_out,
  input wire logic [7:0] axi_araddr_in,
  output logic axi_rvalid_out,
  input wire logic axi_rready_in,
  output logic [31:0] axi_rdata_out,
  output logic [1:0] axi_rresp_out,
  // Link to the reader
  cmd_link_if.host link
);
  import value_recover_pkg::*;

  // Byte-lane merge of a write
  function automatic logic [31:0] merge(input logic [31:0] old,
                                        input logic [31:0] data,
                                        input logic [3:0] strb);
    for (int i = 0; i < 4; i++) begin
      merge[i*8 +: 8] = strb[i] ? data[i*8 +: 8] : old[i*8 +: 8];
    end
  endfunction

  logic awready_reg, wready_reg, bvalid_reg, arready_reg, rvalid_reg;
  logic aw_held_reg, w_held_reg;
  logic [1:0] bresp_reg, rresp_reg;
  logic [7:0] awaddr_reg;
  logic [31:0] wdata_reg, rdata_reg;
  logic [3:0] wstrb_reg;
  logic [31:0] arg0_reg, arg1_reg, arg2_reg;
  logic [7:0] code_reg, buf_addr_reg;
  logic cmd_valid_reg, pending_reg, done_flag_reg;

  // Handshakes and write decode
  wire aw_fire = axi_awvalid_in && awready_reg;
  wire w_fire = axi_wvalid_in && wready_reg;
  wire write_do = aw_held_reg && w_held_reg && !bvalid_reg;
  wire ar_fire = axi_arvalid_in && arready_reg;
  wire wr_cmd = write_do && awaddr_reg == REG_CMD && wstrb_reg[0];
  wire start = wr_cmd && !pending_reg;
  wire wr_known = awaddr_reg == REG_CMD || awaddr_reg == REG_ARG0
    || awaddr_reg == REG_ARG1 || awaddr_reg == REG_ARG2
    || awaddr_reg == REG_STATUS || awaddr_reg == REG_BUF_ADDR;
  wire clr_done = write_do && awaddr_reg == REG_STATUS
    && wstrb_reg[0] && wdata_reg[STAT_DONE_BIT];

  // Status word and read decode
  wire [31:0] status_word = {16'h0000, link.result, 6'h00,
                             done_flag_reg, pending_reg};
  wire rd_known = axi_araddr_in <= REG_BUF_DATA && axi_araddr_in[1:0] == 2'h0;
  wire [31:0] rd_word =
    axi_araddr_in == REG_CMD ? {24'h000000, code_reg} :
    axi_araddr_in == REG_ARG0 ? arg0_reg :
    axi_araddr_in == REG_ARG1 ? arg1_reg :
    axi_araddr_in == REG_ARG2 ? {24'h000000, arg2_reg[7:0]} :
    axi_araddr_in == REG_STATUS ? status_word :
    axi_araddr_in == REG_BUF_ADDR ? {24'h000000, buf_addr_reg} :
    axi_araddr_in == REG_BUF_DATA ? {24'h000000, link.buf_data} : 32'h00000000;

  // Write channels, taken in either order
  always_ff @(posedge clock_in) begin
    if (reset_in) begin
      aw_held_reg <= 1'b0;
      w_held_reg <= 1'b0;
      awready_reg <= 1'b0;
      wready_reg <= 1'b0;
      bvalid_reg <= 1'b0;
      bresp_reg <= RESP_OKAY;
      awaddr_reg <= 8'h00;
      wdata_reg <= 32'h00000000;
      wstrb_reg <= 4'h0;
    end else begin
      if (aw_fire) awaddr_reg <= axi_awaddr_in;
      if (w_fire) wdata_reg <= axi_wdata_in;
      if (w_fire) wstrb_reg <= axi_wstrb_in;
      aw_held_reg <= !write_do && (aw_held_reg || aw_fire);
      w_held_reg <= !write_do && (w_held_reg || w_fire);
      awready_reg <= !write_do && !aw_held_reg && !aw_fire
        && !(bvalid_reg && !axi_bready_in);
      wready_reg <= !write_do && !w_held_reg && !w_fire
        && !(bvalid_reg && !axi_bready_in);
      if (write_do) begin
        bvalid_reg <= 1'b1;
        bresp_reg <= wr_known ? RESP_OKAY : RESP_SLVERR;
      end else if (axi_bready_in) begin
        bvalid_reg <= 1'b0;
      end
    end
  end

  // Read channel
  always_ff @(posedge clock_in) begin
    if (reset_in) begin
      arready_reg <= 1'b0;
      rvalid_reg <= 1'b0;
      rdata_reg <= 32'h00000000;
      rresp_reg <= RESP_OKAY;
    end else if (ar_fire) begin
      arready_reg <= 1'b0;
      rvalid_reg <= 1'b1;
      rdata_reg <= rd_word;
      rresp_reg <= rd_known ? RESP_OKAY : RESP_SLVERR;
    end else if (!rvalid_reg || axi_rready_in) begin
      rvalid_reg <= 1'b0;
      arready_reg <= 1'b1;
    end
  end

  // Argument and control registers
  always_ff @(posedge clock_in) begin
    if (reset_in) begin
      arg0_reg <= 32'h00000000;
      arg1_reg <= 32'h00000000;
      arg2_reg <= 32'h00000000;
      code_reg <= 8'h00;
      buf_addr_reg <= 8'h00;
    end else if (write_do) begin
      if (awaddr_reg == REG_ARG0) arg0_reg <= merge(arg0_reg, wdata_reg, wstrb_reg);
      if (awaddr_reg == REG_ARG1) arg1_reg <= merge(arg1_reg, wdata_reg, wstrb_reg);
      if (awaddr_reg == REG_ARG2) arg2_reg <= merge(arg2_reg, wdata_reg, wstrb_reg);
      if (awaddr_reg == REG_BUF_ADDR && wstrb_reg[0]) buf_addr_reg <= wdata_reg[7:0];
      if (start) code_reg <= wdata_reg[7:0];
    end
  end

  // Command issue, busy tracking and sticky done
  always_ff @(posedge clock_in) begin
    if (reset_in) begin
      cmd_valid_reg <= 1'b0;
      pending_reg <= 1'b0;
      done_flag_reg <= 1'b0;
    end else begin
      cmd_valid_reg <= start;
      pending_reg <= start || (pending_reg && !link.done);
      done_flag_reg <= link.done || (done_flag_reg && !clr_done && !start);
    end
  end

  // Link outputs: argument bytes in list order
  assign link.cmd_valid = cmd_valid_reg;
  assign link.cmd_code = code_reg;
  assign link.cmd_args = {arg2_reg[7:0], arg1_reg, arg0_reg};
  assign link.buf_addr = buf_addr_reg;
  // Bus outputs
  assign axi_awready_out = awready_reg;
  assign axi_wready_out = wready_reg;
  assign axi_bvalid_out = bvalid_reg;
  assign axi_bresp_out = bresp_reg;
  assign axi_arready_out = arready_reg;
  assign axi_rvalid_out = rvalid_reg;
  assign axi_rdata_out = rdata_reg;
  assign axi_rresp_out = rresp_reg;

endmodule
`default_nettype wire

// ### value_recover_pkg.sv
/*
  Shared constants for the value-block recovery command path:
  command code, argument layout, key selector fields, buffer size,
  result codes and the host register map.
  Assumes both ends and the link interface import this package.
*/
package value_recover_pkg;
  // Command and argument layout
  localparam logic [7:0] CMD_RECOVER_VALUE = 8'h10;
  localparam int ARG_BYTES = 9;
  localparam int ARG_W = ARG_BYTES * 8;
  localparam int ARG_BLOCK = 0;
  localparam int ARG_BUF_OFS = 1;
  localparam int ARG_KEY_SEL = 2;
  localparam int ARG_KEY = 3;
  localparam int KEY_BYTES = 6;
  localparam int KEY_W = KEY_BYTES * 8;
  // Key selector fields
  localparam int SEL_KEY_B_BIT = 7;
  localparam int SEL_INLINE_BIT = 6;
  localparam int KEY_IDX_W = 6;
  localparam int KEY_COUNT = 40;
  localparam logic [KEY_IDX_W-1:0] KEY_LAST = 6'h27;
  // Card block and data buffer
  localparam int BLOCK_W = 128;
  localparam int BUF_DEPTH = 256;
  localparam int BUF_AW = 8;
  localparam int RESULT_BYTES = 5;
  localparam logic [2:0] RESULT_LAST = 3'h4;
  // Result codes
  localparam logic [7:0] RES_OK = 8'h00;
  localparam logic [7:0] RES_AUTH_FAIL = 8'h01;
  localparam logic [7:0] RES_CORRUPT = 8'h02;
  localparam logic [7:0] RES_BAD_CMD = 8'h03;
  localparam logic [7:0] RES_BAD_KEY = 8'h05;
  // Host register map, byte addresses
  localparam logic [7:0] REG_CMD = 8'h00;
  localparam logic [7:0] REG_ARG0 = 8'h04;
  localparam logic [7:0] REG_ARG1 = 8'h08;
  localparam logic [7:0] REG_ARG2 = 8'h0C;
  localparam logic [7:0] REG_STATUS = 8'h10;
  localparam logic [7:0] REG_BUF_ADDR = 8'h14;
  localparam logic [7:0] REG_BUF_DATA = 8'h18;
  localparam int STAT_BUSY_BIT = 0;
  localparam int STAT_DONE_BIT = 1;
  localparam int STAT_RES_LSB = 8;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

// ### value_recover_props.sv
/*
  Checker for the command link between host and reader ends:
  start, refusal, completion and result timing.
  Assumes one clock and a synchronous active-high reset.
*/
`timescale 1ns/10ps
`default_nettype none
module value_recover_props
  import value_recover_pkg::*;
(
  // Clock and reset
  input wire logic clock_in,
  input wire logic reset_in,
  // Link signals
  input wire logic cmd_valid,
  input wire logic [7:0] cmd_code,
  input wire logic [value_recover_pkg::ARG_W-1:0] cmd_args,
  input wire logic busy,
  input wire logic done,
  input wire logic [7:0] result
);
  default clocking @(posedge clock_in); endclocking
  default disable iff (reset_in);

  // Start decode helpers
  wire take = cmd_valid && !busy;
  wire is_rec = cmd_code == CMD_RECOVER_VALUE;
  wire key_bad = !cmd_args[22] && (cmd_args[21:16] > KEY_LAST);

  property p_bad_code;
    take && !is_rec |-> ##2 (done && result == RES_BAD_CMD);
  endproperty
  a_bad_code: assert property (p_bad_code)
    else $error("unknown code not refused");
  property p_bad_key;
    take && is_rec && key_bad |-> ##2 (done && result == RES_BAD_KEY);
  endproperty
  a_bad_key: assert property (p_bad_key)
    else $error("key index above range not refused");
  property p_start;
    take && is_rec && !key_bad |=> busy && !done;
  endproperty
  a_start: assert property (p_start)
    else $error("recovery command not started");
  property p_finish;
    $rose(busy) |-> ##[1:200] done;
  endproperty
  a_finish: assert property (p_finish)
    else $error("command never finished");
  property p_done_pulse;
    done |=> !done;
  endproperty
  a_done_pulse: assert property (p_done_pulse)
    else $error("done longer than one cycle");
  property p_busy_drop;
    $fell(busy) |-> done;
  endproperty
  a_busy_drop: assert property (p_busy_drop)
    else $error("busy dropped without done");
  property p_done_idle;
    done |-> !busy;
  endproperty
  a_done_idle: assert property (p_done_idle)
    else $error("busy still high at done");
  // Result settles on entry to the finish state, one cycle ahead of done
  property p_result_hold;
    $changed(result) |=> done;
  endproperty
  a_result_hold: assert property (p_result_hold)
    else $error("result changed outside done");
  property p_one_pulse;
    cmd_valid |=> !cmd_valid;
  endproperty
  a_one_pulse: assert property (p_one_pulse)
    else $error("start strobe longer than one cycle");
endmodule
`default_nettype wire
